// ---- hw/uart_rx_flow_ctrl.sv ----
// Purpose: receive queue, hardware and software flow control, RS-485 direction
// Assumes: receive shifter, transmitter and host logic are outside
// Notes:   holding reads must be at least two cycles apart
//
// What this block does
// RULE1 - queue 64 eleven-bit entries, oldest presented
// RULE2 - holding read advances, error tags follow
// RULE3 - host enables auto request, then sets request
// RULE4 - request rising edge sets handshake flag
// RULE5 - fill at halt level drives request high
// RULE6 - fill down to resume level, request low
// RULE7 - software orders halt above resume level
// RULE8 - host enables automatic clear-to-send handshake
// RULE9 - clear input rising sets handshake flag
// RULE10 - clear high stops transmit at character end
// RULE11 - stop character match halts transmit, flags
// RULE12 - resume character restarts transmit, clears flag
// RULE13 - four flow characters reset to zero
// RULE14 - double mode compares two consecutive characters
// RULE15 - consumed flow characters never enter queue
// RULE16 - send stop/resume characters at fill levels
// RULE17 - special character queued and flagged
// RULE18 - comparisons use configured word length only
// RULE19 - RS-485 direction: idle high, low while sending
// RULE20 - RS-485 direction polarity invertible
// RULE21 - multidrop when enabled without special detect
// RULE22 - multidrop discards data, queues flagged addresses
`timescale 1ns/100ps
module uart_rx_flow_ctrl (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // configuration levels
  input  wire logic                                queueEnable,
  input  wire logic [uart_rx_fc_pkg::WLEN_W-1:0]   wordLenSel,
  input  wire logic                                enhancedEn,
  input  wire logic                                autoRtsEn,
  input  wire logic                                autoCtsEn,
  input  wire logic                                specialCharEn,
  input  wire logic                                swRxFlowEn,
  input  wire logic                                swTxFlowEn,
  input  wire logic                                swDoubleChar,
  input  wire logic                                rtsIntEn,
  input  wire logic                                ctsIntEn,
  input  wire logic                                stopCharIntEn,
  input  wire logic                                rtsRequest,
  input  wire logic [uart_rx_fc_pkg::LEVEL_W-1:0]  haltLevel,
  input  wire logic [uart_rx_fc_pkg::LEVEL_W-1:0]  resumeLevel,
  input  wire logic                                rs485En,
  input  wire logic                                rs485Invert,
  input  wire logic                                multidropEn,
  input  wire logic                                rxEnable,
  // flow character register write
  input  wire logic                                charWrEn,
  input  wire logic [1:0]                          charWrSel,
  input  wire logic [uart_rx_fc_pkg::CHAR_W-1:0]   charWrData,
  // from receive shifter
  input  wire logic                                rxValid,
  input  wire logic [uart_rx_fc_pkg::CHAR_W-1:0]   rxData,
  input  wire logic                                rxParityBit,
  input  wire logic [uart_rx_fc_pkg::TAG_W-1:0]    rxTags,
  // host side
  input  wire logic                                holdingRead,
  input  wire logic                                statusRead,
  input  wire logic                                lsrRead,
  output logic      [uart_rx_fc_pkg::CHAR_W-1:0]   rxHoldingData,
  output logic      [uart_rx_fc_pkg::TAG_W-1:0]    rxErrorTags,
  output logic                                     rxDataReady,
  output logic      [uart_rx_fc_pkg::CNT_W-1:0]    rxFill,
  output logic                                     isrHandshakeFlag,
  output logic                                     isrCharFlag,
  output logic                                     lineStatusFlag,
  // transmitter side
  input  wire logic                                txBusy,
  input  wire logic                                txPending,
  input  wire logic                                txCharDone,
  input  wire logic                                txFlowAck,
  output logic                                     txAllowed,
  output logic                                     txFlowReq,
  output logic      [uart_rx_fc_pkg::CHAR_W-1:0]   txFlowChar,
  // pins
  input  wire logic                                ctsIn,
  output logic                                     rtsOut
);
  import uart_rx_fc_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  rx_queue_if #(.ADDR_W(PTR_W), .DATA_W(ENTRY_W)) qBus ();

  rx_queue_mem #(.DEPTH(QUEUE_DEPTH), .ADDR_W(PTR_W), .DATA_W(ENTRY_W)) uMem (
    .clk   (clk),
    .rst_n (rst_n),
    .q     (qBus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flow character registers

  logic [CHAR_W-1:0] flowChar_q [4];

  for (genvar i = 0; i < 4; i++) begin : gFlowChar
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        flowChar_q[i] <= FLOWCHAR_RESET; // see RULE13
      end else if (charWrEn && charWrSel == 2'(i)) begin
        flowChar_q[i] <= charWrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // character matching

  logic [CHAR_W-1:0] wlMask;

  always_comb begin
    unique case (wordLenSel) // see RULE18
      WLEN_5:  wlMask = 8'h1F;
      WLEN_6:  wlMask = 8'h3F;
      WLEN_7:  wlMask = 8'h7F;
      default: wlMask = 8'hFF;
    endcase
  end

  function automatic logic charEq(input logic [7:0] a, input logic [7:0] b,
                                  input logic [7:0] m);
    return ((a ^ b) & m) == 8'h00;
  endfunction

  logic mStop1, mStop2, mRes1, mRes2;
  assign mRes1  = charEq(rxData, flowChar_q[SEL_RESUME1], wlMask);
  assign mRes2  = charEq(rxData, flowChar_q[SEL_RESUME2], wlMask);
  assign mStop1 = charEq(rxData, flowChar_q[SEL_STOP1], wlMask);
  assign mStop2 = charEq(rxData, flowChar_q[SEL_STOP2], wlMask);

  ////////////////////////////////////////////////////////////////////////////
  // receive staging: one char waits here, or is held as first of a pair

  logic              stageValid_q, stageHold_q, heldStop_q, heldRes_q;
  logic [CHAR_W-1:0] stageChar_q;
  logic [TAG_W-1:0]  stageTags_q;
  logic              dblMode, pairHit, singleStop, singleRes, firstCand;
  logic              mdActive, mdDiscard, specialHit, stopEvent, resumeEvent;
  logic              loadStage, pushStage, full, wrOk, pop;
  logic [CNT_W-1:0]  count_q, haltFill, resumeFill;
  logic [PTR_W-1:0]  wrPtr_q, rdPtr_q;

  assign dblMode    = swRxFlowEn && swDoubleChar;
  // see RULE14
  assign pairHit    = dblMode && stageValid_q && stageHold_q &&
                      ((heldStop_q && mStop2) || (heldRes_q && mRes2));
  assign singleStop = swRxFlowEn && !swDoubleChar && mStop1;
  assign singleRes  = swRxFlowEn && !swDoubleChar && mRes1;
  assign firstCand  = dblMode && (mStop1 || mRes1);
  assign mdActive   = multidropEn && !specialCharEn; // see RULE21
  assign mdDiscard  = mdActive && !rxEnable && !rxParityBit; // see RULE22
  assign specialHit = specialCharEn && mStop2; // see RULE17
  assign stopEvent  = rxValid && ((pairHit && heldStop_q) || singleStop);
  assign resumeEvent = rxValid && ((pairHit && heldRes_q) || singleRes);
  // see RULE15
  assign loadStage  = rxValid && !pairHit && !singleStop && !singleRes && !mdDiscard;
  assign pushStage  = stageValid_q && (!stageHold_q || !dblMode || (rxValid && !pairHit));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stageValid_q <= 1'b0;
      stageHold_q  <= 1'b0;
      heldStop_q   <= 1'b0;
      heldRes_q    <= 1'b0;
      stageChar_q  <= FLOWCHAR_RESET;
      stageTags_q  <= TAGS_NONE;
    end else if (loadStage) begin
      stageValid_q <= 1'b1;
      stageHold_q  <= firstCand;
      heldStop_q   <= dblMode && mStop1;
      heldRes_q    <= dblMode && mRes1;
      stageChar_q  <= rxData;
      // addresses in multidrop carry a parity error tag
      stageTags_q  <= rxTags | {2'b00, mdActive && rxParityBit};
    end else if (pushStage || (rxValid && pairHit)) begin
      stageValid_q <= 1'b0;
      stageHold_q  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // queue pointers and fill

  // single-entry holding register when the queue is off
  assign full  = (count_q == CNT_W'(QUEUE_DEPTH)) || (!queueEnable && count_q != '0);
  // a full queue drops the newest character
  assign wrOk  = pushStage && !full;
  assign pop   = holdingRead && count_q != '0; // see RULE2
  assign haltFill   = CNT_W'({haltLevel, LEVEL_PAD});
  assign resumeFill = CNT_W'({resumeLevel, LEVEL_PAD});

  assign qBus.wrEn   = wrOk; // see RULE1
  assign qBus.wrAddr = wrPtr_q;
  assign qBus.wrData = {stageTags_q, stageChar_q};
  assign qBus.rdAddr = pop ? rdPtr_q + 6'h01 : rdPtr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (wrOk) begin
        wrPtr_q <= wrPtr_q + 6'h01;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 6'h01;
      end
      count_q <= count_q + CNT_W'(wrOk) - CNT_W'(pop);
    end
  end

  // ready trails the count so the memory register has caught up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxDataReady <= 1'b0;
    end else begin
      rxDataReady <= count_q != '0;
    end
  end

  assign rxHoldingData = qBus.rdData[CHAR_W-1:0];
  assign rxErrorTags   = qBus.rdData[ENTRY_W-1:CHAR_W]; // see RULE2
  assign rxFill        = count_q;

  ////////////////////////////////////////////////////////////////////////////
  // request output: auto handshake or RS-485 direction

  logic rtsOn_q, rtsReqD_q, rtsPin, rtsRise, ctsPrev_q, ctsRise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtsOn_q   <= 1'b0;
      rtsReqD_q <= 1'b0;
    end else begin
      rtsReqD_q <= rtsRequest;
      if (!autoRtsEn || !rtsRequest) begin
        rtsOn_q <= rtsRequest; // see RULE3
      end else if (count_q >= haltFill) begin
        rtsOn_q <= 1'b0; // see RULE5
      end else if (count_q <= resumeFill || !rtsReqD_q) begin
        rtsOn_q <= 1'b1; // see RULE6
      end
    end
  end

  // see RULE19 RULE20
  assign rtsPin  = rs485En ? ((!(txPending || txBusy)) ^ rs485Invert) : !rtsOn_q;
  assign rtsRise = !rtsOut && rtsPin;
  assign ctsRise = !ctsPrev_q && ctsIn;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtsOut    <= 1'b1;
      ctsPrev_q <= 1'b1;
    end else begin
      rtsOut    <= rtsPin;
      ctsPrev_q <= ctsIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags, set wins over clear

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isrHandshakeFlag <= 1'b0;
    end else if ((rtsRise && rtsIntEn && enhancedEn) || // see RULE4
                 (ctsRise && ctsIntEn && enhancedEn)) begin // see RULE9
      isrHandshakeFlag <= 1'b1;
    end else if (statusRead) begin
      isrHandshakeFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isrCharFlag <= 1'b0;
    end else if ((stopEvent && stopCharIntEn) || // see RULE11
                 (loadStage && specialHit)) begin // see RULE17
      isrCharFlag <= 1'b1;
    end else if (resumeEvent || statusRead) begin
      isrCharFlag <= 1'b0; // see RULE12
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineStatusFlag <= 1'b0;
    end else if (wrOk && stageTags_q != TAGS_NONE) begin
      lineStatusFlag <= 1'b1; // see RULE22
    end else if (lsrRead) begin
      lineStatusFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit gating

  logic ctsHalt_q, xoffHalt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctsHalt_q <= 1'b0;
    end else if (!autoCtsEn || !ctsIn) begin
      ctsHalt_q <= 1'b0;
    end else if (txCharDone || !txBusy) begin
      ctsHalt_q <= 1'b1; // see RULE10
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xoffHalt_q <= 1'b0;
    end else if (!swRxFlowEn || resumeEvent) begin
      xoffHalt_q <= 1'b0; // see RULE12
    end else if (stopEvent) begin
      xoffHalt_q <= 1'b1; // see RULE11
    end
  end

  // transmitter samples this only between characters
  assign txAllowed = !ctsHalt_q && !xoffHalt_q;

  ////////////////////////////////////////////////////////////////////////////
  // sending our own stop and resume characters

  txflow_state_type txState_q;
  logic             remoteStopped_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_q       <= TXF_IDLE;
      remoteStopped_q <= 1'b0;
      txFlowChar      <= FLOWCHAR_RESET;
    end else begin
      unique case (txState_q) // see RULE16
        TXF_IDLE: begin
          if (!swTxFlowEn) begin
            remoteStopped_q <= 1'b0;
          end else if (!remoteStopped_q && count_q >= haltFill) begin
            txState_q  <= TXF_STOP1;
            txFlowChar <= flowChar_q[SEL_STOP1];
          end else if (remoteStopped_q && count_q <= resumeFill) begin
            txState_q  <= TXF_RES1;
            txFlowChar <= flowChar_q[SEL_RESUME1];
          end
        end
        TXF_STOP1, TXF_RES1: begin
          if (txFlowAck && swDoubleChar) begin
            txState_q  <= (txState_q == TXF_STOP1) ? TXF_STOP2 : TXF_RES2;
            txFlowChar <= (txState_q == TXF_STOP1) ? flowChar_q[SEL_STOP2]
                                                   : flowChar_q[SEL_RESUME2];
          end else if (txFlowAck) begin
            txState_q       <= TXF_IDLE;
            remoteStopped_q <= (txState_q == TXF_STOP1);
          end
        end
        TXF_STOP2, TXF_RES2: begin
          if (txFlowAck) begin
            txState_q       <= TXF_IDLE;
            remoteStopped_q <= (txState_q == TXF_STOP2);
          end
        end
      endcase
    end
  end

  assign txFlowReq = txState_q != TXF_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_queue_bound: assert property (count_q <= CNT_W'(QUEUE_DEPTH)) // see RULE1
    else $error("queue fill above depth");

  a_pop_advance: assert property (pop |=> rdPtr_q == $past(rdPtr_q) + 6'h01) // see RULE2
    else $error("holding read did not advance");

  a_rts_halt: assert property ( // see RULE5
    (autoRtsEn && !rs485En && count_q >= haltFill)[*2] |=> rtsOut)
    else $error("request not high at halt level");

  a_rts_resume: assert property ( // see RULE6
    (autoRtsEn && !rs485En && rtsRequest && rtsReqD_q && count_q <= resumeFill &&
     count_q < haltFill)[*2] |=> !rtsOut)
    else $error("request not low at resume level");

  a_rts_irq: assert property ( // see RULE4
    $rose(rtsOut) && $past(rtsIntEn && enhancedEn) |-> isrHandshakeFlag)
    else $error("request rise not flagged");

  a_cts_irq: assert property ( // see RULE9
    ctsRise && ctsIntEn && enhancedEn |=> isrHandshakeFlag)
    else $error("clear rise not flagged");

  a_cts_stop: assert property ( // see RULE10
    autoCtsEn && ctsIn && !txBusy |=> !txAllowed)
    else $error("transmit not held by clear input");

  // equal stop and resume characters let the resume win
  a_xoff_halt: assert property ( // see RULE11
    stopEvent && !resumeEvent |=> !txAllowed ##0 xoffHalt_q)
    else $error("stop character did not halt");

  a_xon_resume: assert property ( // see RULE12
    resumeEvent && !stopEvent && !(loadStage && specialHit) |=> !isrCharFlag && !xoffHalt_q)
    else $error("resume character did not restart");

  a_flow_drop: assert property ((stopEvent || resumeEvent) |=> !stageValid_q) // see RULE15
    else $error("flow character was staged");

  a_rs485_idle: assert property ( // see RULE19
    (rs485En && !txPending && !txBusy && $stable(rs485Invert))[*2] |->
    rtsOut == !rs485Invert)
    else $error("direction output not idle level");

  a_md_discard: assert property ( // see RULE22
    rxValid && mdDiscard && !stageValid_q |=> !stageValid_q)
    else $error("multidrop data not discarded");

  c_halt_reached: cover property (autoRtsEn && $rose(rtsOut));
  c_pair_match:   cover property (rxValid && pairHit);
  c_special_char: cover property (loadStage && specialHit);
  c_flow_sent:    cover property (txFlowReq && txFlowAck);
endmodule

// ---- hw/uart_rx_fc_pkg.sv ----
// Purpose: shared constants and types of the receive flow-control block
// Assumes: one channel, 64-entry receive queue
// Notes:   level nibbles count steps of four entries
package uart_rx_fc_pkg;
  localparam int          QUEUE_DEPTH    = 64;
  localparam int          CHAR_W         = 8;
  localparam int          TAG_W          = 3;
  localparam int          ENTRY_W        = CHAR_W + TAG_W;
  localparam int          PTR_W          = 6;
  localparam int          CNT_W          = 7;
  localparam int          LEVEL_W        = 4;
  localparam int          WLEN_W         = 2;
  // tag positions inside a queue entry: parity, framing, break
  localparam int          TAG_PARITY     = 0;
  localparam logic [1:0]  LEVEL_PAD      = 2'h0;
  localparam logic [7:0]  FLOWCHAR_RESET = 8'h00;
  localparam logic [2:0]  TAGS_NONE      = 3'h0;
  // flow character register select
  localparam logic [1:0]  SEL_RESUME1    = 2'h0;
  localparam logic [1:0]  SEL_RESUME2    = 2'h1;
  localparam logic [1:0]  SEL_STOP1      = 2'h2;
  localparam logic [1:0]  SEL_STOP2      = 2'h3;
  // word length codes
  localparam logic [1:0]  WLEN_5         = 2'h0;
  localparam logic [1:0]  WLEN_6         = 2'h1;
  localparam logic [1:0]  WLEN_7         = 2'h2;
  typedef enum logic [2:0] {
    TXF_IDLE,
    TXF_STOP1,
    TXF_STOP2,
    TXF_RES1,
    TXF_RES2
  } txflow_state_type;
endpackage

// ---- hw/rx_queue_if.sv ----
// Purpose: carrier between the flow-control logic and the queue memory
// Assumes: one write and one read port
// Notes:   read data come from a register in the memory
`timescale 1ns/100ps
interface rx_queue_if #(parameter int ADDR_W = 6, parameter int DATA_W = 11);
  logic              wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrData;
  logic [ADDR_W-1:0] rdAddr;
  logic [DATA_W-1:0] rdData;
  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// ---- hw/rx_queue_mem.sv ----
// Purpose: storage of the receive queue entries
// Assumes: rdAddr is presented one cycle before the data are wanted
// Notes:   storage itself has no reset, only the output register
`timescale 1ns/100ps
module rx_queue_mem #(
  parameter int DEPTH  = 64,
  parameter int ADDR_W = 6,
  parameter int DATA_W = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ports
  rx_queue_if.mem  q
);
  logic [DATA_W-1:0] store [DEPTH];

  always_ff @(posedge clk) begin
    if (q.wrEn) begin
      store[q.wrAddr] <= q.wrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.rdData <= '0;
    end else begin
      q.rdData <= store[q.rdAddr];
    end
  end
endmodule

// ---- bench/flow_partner.sv ----
// Purpose: far-side transmitter that takes flow characters
// Assumes: one character in flight at a time
// Notes:   slowAck stretches the answer to a request
`timescale 1ns/100ps
module flow_partner (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // request from block, slowAck from bench
  input  wire logic       txFlowReq,
  input  wire logic [7:0] txFlowChar,
  input  wire logic       slowAck,
  // answer and record
  output logic            txFlowAck,
  output logic            txBusy,
  output logic            txCharDone,
  output logic      [7:0] sentChar,
  output logic      [3:0] sentCount
);
  logic [3:0] wait_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {txFlowAck, txBusy, txCharDone, sentChar, sentCount, wait_q} <= '0;
    end else begin
      txFlowAck <= 1'b0;
      txCharDone <= 1'b0;
      wait_q <= wait_q + 4'h1;
      if (txBusy && wait_q == 4'h4) begin
        txBusy <= 1'b0;
        txCharDone <= 1'b1;
      end else if (!txBusy && !(txFlowReq && !txFlowAck)) begin
        wait_q <= 4'h0;
      end else if (!txBusy && wait_q == (slowAck ? 4'h6 : 4'h1)) begin
        // char goes out on the line
        txFlowAck <= 1'b1;
        txBusy <= 1'b1;
        sentChar <= txFlowChar;
        sentCount <= sentCount + 4'h1;
        wait_q <= 4'h0;
      end
    end
  end
endmodule

// ---- bench/testbench.sv ----
// Purpose: directed checks of receive queue and flow control
// Assumes: inputs change 1 ns after the rising edge
// Notes:   levels scaled by four entries
`timescale 1ns/100ps
module testbench;
  import uart_rx_fc_pkg::*;
  logic clk, rst_n, queueEnable, enhancedEn, autoRtsEn, autoCtsEn, specialCharEn;
  logic swRxFlowEn, swTxFlowEn, swDoubleChar, rtsIntEn, ctsIntEn, stopCharIntEn;
  logic rtsRequest, rs485En, rs485Invert, multidropEn, rxEnable, charWrEn, rxValid;
  logic rxParityBit, holdingRead, statusRead, lsrRead, txPending, ctsIn, slowAck;
  logic rxDataReady, isrHandshakeFlag, isrCharFlag, lineStatusFlag;
  logic txBusy, txCharDone, txFlowAck, txAllowed, txFlowReq, rtsOut;
  logic [1:0] wordLenSel, charWrSel;
  logic [3:0] haltLevel, resumeLevel, sentCount;
  logic [7:0] charWrData, rxData, rxHoldingData, txFlowChar, sentChar;
  logic [2:0] rxTags, rxErrorTags;
  logic [6:0] rxFill;
  int         fail_count, cmp_count, cycles;

  uart_rx_flow_ctrl DUT (.*);
  flow_partner      partner (.*);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard, well above the run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rx(input logic [7:0] d, input logic p, input logic [2:0] t);
    rxValid = 1'b1;
    rxData = d;
    rxParityBit = p;
    rxTags = t;
    tick(1);
    rxValid = 1'b0;
    tick(3);
  endtask

  task automatic wrc(input logic [1:0] s, input logic [7:0] d);
    charWrEn = 1'b1;
    charWrSel = s;
    charWrData = d;
    tick(1);
    charWrEn = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] d, input logic [2:0] t);
    chk({rxErrorTags, rxHoldingData}, {t, d});
    holdingRead = 1'b1;
    tick(1);
    holdingRead = 1'b0;
    tick(2);
  endtask

  task automatic clr();
    statusRead = 1'b1;
    lsrRead = 1'b1;
    tick(1);
    statusRead = 1'b0;
    lsrRead = 1'b0;
  endtask

  task automatic done(input string name);
    $display("test %s ended, mismatches so far %0d", name, fail_count);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, queueEnable, enhancedEn, autoRtsEn, autoCtsEn, specialCharEn, swRxFlowEn,
     swTxFlowEn, swDoubleChar, rtsIntEn, ctsIntEn, stopCharIntEn, rtsRequest, rs485En,
     rs485Invert, multidropEn, rxEnable, charWrEn, rxValid, rxParityBit, holdingRead,
     statusRead, lsrRead, txPending, ctsIn, slowAck, wordLenSel, charWrSel, haltLevel,
     resumeLevel, charWrData, rxData, rxTags} = '0;
    queueEnable = 1'b1;
    rxEnable = 1'b1;
    wordLenSel = 2'h3;
    tick(16);
    rst_n = 1'b1;
    tick(1);
    chk({rtsOut, txAllowed, txFlowReq, rxDataReady, 5'h0, rxFill}, 16'hC000);
    done("reset");
    rx(8'h41, 1'b0, 3'h0);
    rx(8'h42, 1'b0, 3'h2);
    rx(8'h43, 1'b0, 3'h4);
    chk({rxDataReady, rxFill}, 16'h0083);
    chk(lineStatusFlag, 16'h0001);
    rd(8'h41, 3'h0);
    rd(8'h42, 3'h2);
    rd(8'h43, 3'h4);
    chk({rxDataReady, rxFill}, 16'h0000);
    // queue off: one holding entry, the newer character is dropped
    queueEnable = 1'b0;
    rx(8'h51, 1'b0, 3'h0);
    rx(8'h52, 1'b0, 3'h0);
    chk(rxFill, 16'h0001);
    rd(8'h51, 3'h0);
    queueEnable = 1'b1;
    clr();
    done("queue");
    swRxFlowEn = 1'b1;
    stopCharIntEn = 1'b1;
    wrc(SEL_RESUME1, 8'h11);
    rx(8'h00, 1'b0, 3'h0);
    chk({rxFill, txAllowed, isrCharFlag}, 16'h0001);
    rx(8'h11, 1'b0, 3'h0);
    chk({rxFill, txAllowed, isrCharFlag}, 16'h0002);
    wordLenSel = WLEN_5;
    wrc(SEL_STOP1, 8'h13);
    rx(8'hF3, 1'b0, 3'h0);
    chk({rxFill, txAllowed}, 16'h0000);
    rx(8'hF1, 1'b0, 3'h0);
    chk({rxFill, txAllowed}, 16'h0001);
    wordLenSel = 2'h3;
    rx(8'hF3, 1'b0, 3'h0);
    rd(8'hF3, 3'h0);
    swDoubleChar = 1'b1;
    wrc(SEL_STOP1, 8'hA1);
    wrc(SEL_STOP2, 8'hA2);
    wrc(SEL_RESUME2, 8'h22);
    rx(8'hA1, 1'b0, 3'h0);
    rx(8'hA2, 1'b0, 3'h0);
    chk({rxFill, txAllowed}, 16'h0000);
    rx(8'h11, 1'b0, 3'h0);
    rx(8'h22, 1'b0, 3'h0);
    chk({rxFill, txAllowed}, 16'h0001);
    rx(8'hA1, 1'b0, 3'h0);
    rx(8'h33, 1'b0, 3'h0);
    chk(rxFill, 16'h0002);
    rd(8'hA1, 3'h0);
    rd(8'h33, 3'h0);
    swDoubleChar = 1'b0;
    swRxFlowEn = 1'b0;
    clr();
    done("software flow");
    specialCharEn = 1'b1;
    rx(8'hA2, 1'b0, 3'h0);
    chk({rxFill, isrCharFlag}, 16'h0003);
    rd(8'hA2, 3'h0);
    specialCharEn = 1'b0;
    clr();
    done("special");
    // levels first, else a zero halt level fires at once
    haltLevel = 4'h1;
    resumeLevel = 4'h0;
    enhancedEn = 1'b1;
    rtsIntEn = 1'b1;
    swTxFlowEn = 1'b1;
    slowAck = 1'b1;
    autoRtsEn = 1'b1;
    tick(1);
    rtsRequest = 1'b1;
    tick(3);
    chk(rtsOut, 16'h0000);
    for (int i = 0; i < 5; i++) rx(8'(8'h60 + i), 1'b0, 3'h0);
    tick(10);
    chk({rtsOut, isrHandshakeFlag, rxFill}, 16'h0185);
    chk({sentCount, sentChar}, 16'h01A1);
    for (int i = 0; i < 5; i++) rd(8'(8'h60 + i), 3'h0);
    tick(12);
    chk(rtsOut, 16'h0000);
    chk({sentCount, sentChar}, 16'h0211);
    autoRtsEn = 1'b0;
    swTxFlowEn = 1'b0;
    clr();
    done("auto request");
    autoCtsEn = 1'b1;
    ctsIntEn = 1'b1;
    ctsIn = 1'b1;
    tick(2);
    chk({txAllowed, isrHandshakeFlag}, 16'h0001);
    ctsIn = 1'b0;
    tick(2);
    chk(txAllowed, 16'h0001);
    autoCtsEn = 1'b0;
    done("auto clear");
    rs485En = 1'b1;
    for (int i = 0; i < 4; i++) begin
      txPending = i[0];
      rs485Invert = i[1];
      tick(3);
      chk(rtsOut, 16'(!i[0] ^ i[1]));
    end
    {txPending, rs485En, rs485Invert} = '0;
    done("direction");
    clr();
    multidropEn = 1'b1;
    rxEnable = 1'b0;
    rx(8'h70, 1'b0, 3'h0);
    chk(rxFill, 16'h0000);
    rx(8'h71, 1'b1, 3'h0);
    chk({lineStatusFlag, rxFill}, 16'h0081);
    rd(8'h71, 3'h1);
    rxEnable = 1'b1;
    rx(8'h72, 1'b0, 3'h0);
    rd(8'h72, 3'h0);
    done("multidrop");
    wrap_up();
  end
endmodule
